// ===== core/imsk_top.sv
/*
 Interrupt mask words and in-service level tracker, with an Avalon-MM
 slave for software. Assumes the CPU core sequencer on the same clock
 drives acknowledge, return and per-source mask-flag strobes.
*/
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
`include "imsk_cfg.svh"

module imsk_top
   import imsk_pkg::*;
#(
   parameter int ADDR_W = 18
) (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic [1:0] AVS_RESPONSE_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic [31:0] REQ_IN,
   input wire logic [63:0] PRIO_IN,
   input wire imsk_ack_type ACK_IN,
   input wire imsk_ret_type RET_IN,
   input wire imsk_flag_wr_type FLAG_WR_IN,
   input wire logic WDOG_FIRST_IN,
   output logic [31:0] REQ_GRANTABLE_OUT,
   output logic [31:0] MASK_OUT,
   output logic [7:0] INSERVICE_OUT
);

   // the index must fit the address above the byte lanes
   if (ADDR_W < 18) begin : g_bad_addr_w
      $error("imsk_top: ADDR_W must be at least 18");
   end

   // merge one 16-bit word under the two low byte enables
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0] be);
      logic [15:0] res;
      res = old;
      if (be[0]) begin
         res[7:0] = wd[7:0];
      end
      if (be[1]) begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction

   // one-hot of the in-service bit that ranks highest
   function automatic logic [7:0] pick_top(input logic [7:0] isr,
                                           input logic wd_first);
      logic [7:0] sel;
      sel = 8'h00;
      if (wd_first && isr[`IMSK_BIT_WDOG]) begin
         sel[`IMSK_BIT_WDOG] = 1'h1;
      end else if (isr[`IMSK_BIT_PIN_NMI]) begin
         sel[`IMSK_BIT_PIN_NMI] = 1'h1;
      end else if (isr[`IMSK_BIT_WDOG]) begin
         sel[`IMSK_BIT_WDOG] = 1'h1;
      end else begin
         // descending walk leaves the lowest set level, level 0 wins
         for (int i = `IMSK_NUM_LEVELS - 1; i >= 0; i--) begin
            if (isr[i]) begin
               sel = 8'h00;
               sel[i] = 1'h1;
            end
         end
      end
      return sel;
   endfunction

   logic [31:0] mask_reg;
   logic [31:0] mask_next;
   logic [7:0] isr_reg;
   logic [7:0] isr_next;
   logic [31:0] rdata_reg;
   logic [1:0] resp_reg;
   imsk_bus_state_type bus_reg;
   logic [ADDR_W-3:0] word_idx;
   logic hit_isr;
   logic hit_first;
   logic hit_second;
   logic bus_req;
   logic wr_commit;
   logic [1:0] ack_level;

   // wired-one pattern as a named vector, so single bits can be picked
   localparam logic [31:0] MASK_FIXED = `IMSK_MASK_FIXED;

   // address decode on the word index
   assign word_idx = AVS_ADDRESS_IN[ADDR_W-1:2];
   assign hit_isr = word_idx == (ADDR_W-2)'(`IMSK_IDX_INSERVICE);
   assign hit_first = word_idx == (ADDR_W-2)'(`IMSK_IDX_MASK_FIRST);
   assign hit_second = word_idx == (ADDR_W-2)'(`IMSK_IDX_MASK_SECOND);
   assign bus_req = AVS_READ_IN || AVS_WRITE_IN;

   // every access holds for exactly one wait cycle
   assign AVS_WAITREQUEST_OUT = bus_req && (bus_reg == BUS_IDLE);
   assign wr_commit = AVS_WRITE_IN && (bus_reg == BUS_DONE);
   assign AVS_READDATA_OUT = rdata_reg;
   assign AVS_RESPONSE_OUT = resp_reg;

   // bus sequencer
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         bus_reg <= BUS_IDLE;
      end else begin
         unique case (bus_reg)
            BUS_IDLE: begin
               if (bus_req) begin
                  bus_reg <= BUS_DONE;
               end
            end
            BUS_DONE: begin
               bus_reg <= BUS_IDLE;
            end
         endcase
      end
   end

   // read data and response captured in the wait cycle
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         rdata_reg <= 32'h0000_0000;
         resp_reg <= `IMSK_RESP_OKAY;
      end else if (bus_req && bus_reg == BUS_IDLE) begin
         rdata_reg <= 32'h0000_0000;
         resp_reg <= `IMSK_RESP_OKAY;
         if (hit_isr) begin
            rdata_reg[7:0] <= isr_reg;
         end else if (hit_first) begin
            rdata_reg[15:0] <= mask_reg[15:0];
         end else if (hit_second) begin
            rdata_reg[15:0] <= mask_reg[31:16];
         end else begin
            resp_reg <= `IMSK_RESP_DECERR;
         end
      end
   end

   // shared mask storage; the per-source strobe lands after the bus
   // write, so it wins on the same bit in the same cycle
   always_comb begin
      mask_next = mask_reg;
      if (wr_commit && hit_first) begin
         mask_next[15:0] = merge16(mask_reg[15:0], AVS_WRITEDATA_IN[15:0],
                                   AVS_BYTEENABLE_IN[1:0]);
      end
      if (wr_commit && hit_second) begin
         mask_next[31:16] = merge16(mask_reg[31:16], AVS_WRITEDATA_IN[15:0],
                                    AVS_BYTEENABLE_IN[1:0]);
      end
      if (FLAG_WR_IN.wr) begin
         mask_next[FLAG_WR_IN.idx] = FLAG_WR_IN.val;
      end
      // unused sources stay masked whatever is written
      mask_next = mask_next | `IMSK_MASK_FIXED;
   end

   // mask register
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         mask_reg <= {`IMSK_MASK_RESET, `IMSK_MASK_RESET};
      end else begin
         mask_reg <= mask_next;
      end
   end

   assign MASK_OUT = mask_reg;
   // only unmasked requests are offered for acknowledge
   assign REQ_GRANTABLE_OUT = REQ_IN & ~mask_reg;

   // level of the source being acknowledged
   assign ack_level = PRIO_IN[{ACK_IN.src, 1'h0} +: 2];

   // in-service update: clear first, then set, so a new acknowledge
   // in the return cycle is never lost
   always_comb begin
      isr_next = isr_reg;
      if (RET_IN.valid) begin
         unique case (RET_IN.kind)
            RET_VECTORED, RET_CONTEXT: begin
               isr_next = isr_reg & ~pick_top(isr_reg,
                                              WDOG_FIRST_IN);
            end
            RET_BREAK, RET_BREAK_CONTEXT: begin
               isr_next = isr_reg;
            end
         endcase
      end
      if (ACK_IN.valid) begin
         unique case (ACK_IN.kind)
            ACK_MASKABLE: begin
               if (!mask_reg[ACK_IN.src]) begin
                  isr_next[ack_level] = 1'h1;
               end
            end
            ACK_PIN_NMI: begin
               isr_next[`IMSK_BIT_PIN_NMI] = 1'h1;
            end
            ACK_WATCHDOG: begin
               isr_next[`IMSK_BIT_WDOG] = 1'h1;
            end
            default: begin
               isr_next = isr_next;
            end
         endcase
      end
      // reserved bits never hold a one
      isr_next[`IMSK_ISR_ZERO_HI:`IMSK_ISR_ZERO_LO] = 2'h0;
   end

   // bus writes to the in-service word are dropped on purpose
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         isr_reg <= `IMSK_ISR_RESET;
      end else begin
         isr_reg <= isr_next;
      end
   end

   assign INSERVICE_OUT = isr_reg;

   // reset release value of the in-service register
   property p_isr_reset;
      @(posedge CLK_IN)
      (RESETN_IN && !$past(RESETN_IN)) |-> $past(isr_reg) == 8'h00;
   endproperty
   a_isr_reset: assert property (p_isr_reset)
      else $error("in-service not cleared by reset");

   property p_fixed_mask;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (mask_reg & `IMSK_MASK_FIXED) == `IMSK_MASK_FIXED;
   endproperty
   a_fixed_mask: assert property (p_fixed_mask)
      else $error("wired-one mask bit lost");

   property p_flag_view;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      FLAG_WR_IN.wr |=> MASK_OUT[$past(FLAG_WR_IN.idx)] ==
         ($past(FLAG_WR_IN.val) || MASK_FIXED[$past(FLAG_WR_IN.idx)]);
   endproperty
   a_flag_view: assert property (p_flag_view)
      else $error("per-source flag write not seen in mask word");

   property p_masked_blocked;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (ACK_IN.valid && ACK_IN.kind == ACK_MASKABLE &&
       mask_reg[ACK_IN.src] && !RET_IN.valid) |=> $stable(isr_reg);
   endproperty
   a_masked_blocked: assert property (p_masked_blocked)
      else $error("masked request reached in-service");

   property p_level_set;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (ACK_IN.valid && ACK_IN.kind == ACK_MASKABLE &&
       !mask_reg[ACK_IN.src]) |=> isr_reg[$past(ack_level)];
   endproperty
   a_level_set: assert property (p_level_set)
      else $error("level bit not set on acknowledge");

   property p_nmi_set;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (ACK_IN.valid && ACK_IN.kind != ACK_MASKABLE) |=>
         (isr_reg[7] || isr_reg[6]) &&
         ($past(ACK_IN.kind) == ACK_PIN_NMI ? isr_reg[7] : isr_reg[6]);
   endproperty
   a_nmi_set: assert property (p_nmi_set)
      else $error("non-maskable bit not set on acknowledge");

   // pin bit only leaves service through a return strobe
   property p_nmi_hold;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (isr_reg[`IMSK_BIT_PIN_NMI] && !RET_IN.valid) |=>
         isr_reg[`IMSK_BIT_PIN_NMI];
   endproperty
   a_nmi_hold: assert property (p_nmi_hold)
      else $error("pin non-maskable bit dropped without return");

   property p_ret_clear;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (RET_IN.valid && !ACK_IN.valid &&
       (RET_IN.kind == RET_VECTORED || RET_IN.kind == RET_CONTEXT)) |=>
         isr_reg == ($past(isr_reg) &
                     ~pick_top($past(isr_reg), $past(WDOG_FIRST_IN)));
   endproperty
   a_ret_clear: assert property (p_ret_clear)
      else $error("return cleared the wrong in-service bit");

   property p_break_keep;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (RET_IN.valid && !ACK_IN.valid &&
       (RET_IN.kind == RET_BREAK || RET_IN.kind == RET_BREAK_CONTEXT))
         |=> $stable(isr_reg);
   endproperty
   a_break_keep: assert property (p_break_keep)
      else $error("break return changed in-service");

   property p_zero_bits;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      INSERVICE_OUT[5:4] == 2'h0;
   endproperty
   a_zero_bits: assert property (p_zero_bits)
      else $error("reserved in-service bits set");

   property p_isr_ro;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (wr_commit && hit_isr && !ACK_IN.valid && !RET_IN.valid)
         |=> $stable(isr_reg);
   endproperty
   a_isr_ro: assert property (p_isr_ro)
      else $error("bus write altered in-service");

   property p_bus_answer;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      bus_req |-> ##[0:1] !AVS_WAITREQUEST_OUT;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus answer late");

   c_ack_level: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      ACK_IN.valid && ACK_IN.kind == ACK_MASKABLE && !mask_reg[ACK_IN.src]);
   c_ret_nested: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      RET_IN.valid && RET_IN.kind == RET_VECTORED && isr_reg[7] &&
      isr_reg[0]);
   c_mask_write: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      wr_commit && hit_first);
   c_ack_and_ret: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      ACK_IN.valid && RET_IN.valid);

endmodule

// ===== core/imsk_cfg.svh
/*
 Register indices, reset values and bit positions of the interrupt mask
 and in-service block. Assumes inclusion by imsk_top only.
*/
`ifndef IMSK_CFG_SVH
`define IMSK_CFG_SVH

// register indices; byte address is four times the index
`define IMSK_IDX_INSERVICE 16'hFFA8
`define IMSK_IDX_MASK_FIRST 16'hFFAC
`define IMSK_IDX_MASK_SECOND 16'hFFAE

// reset values
`define IMSK_MASK_RESET 16'hFFFF
`define IMSK_ISR_RESET 8'h00

// mask bits that are wired to one, {second, first}
`define IMSK_MASK_FIXED 32'hFD80_0080

// in-service bit positions
`define IMSK_BIT_PIN_NMI 7
`define IMSK_BIT_WDOG 6
`define IMSK_ISR_ZERO_HI 5
`define IMSK_ISR_ZERO_LO 4
`define IMSK_NUM_LEVELS 4

// avalon response codes
`define IMSK_RESP_OKAY 2'h0
`define IMSK_RESP_DECERR 2'h3

`endif

// ===== core/imsk_pkg.sv
/*
 Types shared by the interrupt mask and in-service block.
 Assumes imsk_cfg.svh is on the include path.
*/
package imsk_pkg;
   // kind of interrupt being acknowledged by the core
   typedef enum logic [1:0] {
      ACK_MASKABLE,
      ACK_PIN_NMI,
      ACK_WATCHDOG
   } imsk_ack_kind_type;

   // return instruction being executed
   typedef enum logic [1:0] {
      RET_VECTORED,
      RET_CONTEXT,
      RET_BREAK,
      RET_BREAK_CONTEXT
   } imsk_ret_kind_type;

   typedef struct packed {
      logic valid;
      imsk_ack_kind_type kind;
      logic [4:0] src;
   } imsk_ack_type;

   typedef struct packed {
      logic valid;
      imsk_ret_kind_type kind;
   } imsk_ret_type;

   typedef struct packed {
      logic wr;
      logic [4:0] idx;
      logic val;
   } imsk_flag_wr_type;

   typedef enum logic {
      BUS_IDLE,
      BUS_DONE
   } imsk_bus_state_type;
endpackage

// ===== verification/imsk_core_model.sv
/*
 Behavioural CPU core sequencer: acknowledge, return and mask-flag strobes.
 Assumes the block takes each strobe at a rising edge of the shared clock.
*/
`timescale 1ns/10ps
module imsk_core_model
   import imsk_pkg::*;
(
   input wire logic clk_in,
   output imsk_ack_type ack_out,
   output imsk_ret_type ret_out,
   output imsk_flag_wr_type flag_out
);
   // strobes idle until a test asks for a pulse
   initial begin
      ack_out = '0;
      ret_out = '0;
      flag_out = '0;
   end

   // one-cycle acknowledge; acks a masked source only when told to
   task automatic ack(input imsk_ack_kind_type k, input logic [4:0] s);
      @(posedge clk_in);
      ack_out <= '{1'b1, k, s};
      @(posedge clk_in);
      ack_out.valid <= 1'b0;
   endtask

   // one-cycle return strobe, kind as decoded by the core
   task automatic ret(input imsk_ret_kind_type k);
      @(posedge clk_in);
      ret_out <= '{1'b1, k};
      @(posedge clk_in);
      ret_out.valid <= 1'b0;
   endtask

   // per-source mask flag write, the other view of the mask words
   task automatic flag(input logic [4:0] i, input logic v);
      @(posedge clk_in);
      flag_out <= '{1'b1, i, v};
      @(posedge clk_in);
      flag_out.wr <= 1'b0;
   endtask
endmodule

// ===== verification/tb_top.sv
/*
 Self-checking bench for the mask words and in-service tracker.
 Assumes imsk_top, imsk_pkg and the core model are compiled before it.
*/
`timescale 1ns/10ps
module tb_top
   import imsk_pkg::*;
();
   typedef struct packed {
      logic [17:0] a;
      logic [15:0] d;
      logic [1:0] b;
      logic [15:0] e;
      logic [1:0] r;
   } imsk_row_type;
   logic clk, resetn, rd, wr, waitreq, wdog_first;
   logic [17:0] addr;
   logic [31:0] wdata, rdata, rd_out, req, grant, mask;
   logic [3:0] be;
   logic [1:0] resp, resp_out;
   logic [63:0] prio;
   logic [7:0] isr;
   imsk_ack_type ack;
   imsk_ret_type ret;
   imsk_flag_wr_type flag;
   int miscompares, checked;
   // ordinary bus cases; in-service is never written by software
   imsk_row_type rows [5] = '{
      '{18'h3FEB0, 16'h0000, 2'h3, 16'h0080, 2'h0},
      '{18'h3FEB8, 16'h0000, 2'h3, 16'hFD80, 2'h0},
      '{18'h3FEB0, 16'h1234, 2'h1, 16'h00B4, 2'h0},
      '{18'h3FEB8, 16'hFFFF, 2'h2, 16'hFF80, 2'h0},
      '{18'h00000, 16'hFFFF, 2'h3, 16'h0000, 2'h3}};
   logic [4:0] srcs [4] = '{5'h00, 5'h01, 5'h06, 5'h0B};
   logic [7:0] rets [6] = '{8'h4F, 8'h0F, 8'h0E, 8'h0C, 8'h08, 8'h00};

   imsk_top u_imsk_top (.CLK_IN(clk), .RESETN_IN(resetn),
      .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
      .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
      .AVS_READDATA_OUT(rd_out), .AVS_RESPONSE_OUT(resp_out),
      .AVS_WAITREQUEST_OUT(waitreq), .REQ_IN(req), .PRIO_IN(prio),
      .ACK_IN(ack), .RET_IN(ret), .FLAG_WR_IN(flag),
      .WDOG_FIRST_IN(wdog_first), .REQ_GRANTABLE_OUT(grant),
      .MASK_OUT(mask), .INSERVICE_OUT(isr));
   imsk_core_model u_imsk_core_model (.clk_in(clk), .ack_out(ack),
      .ret_out(ret), .flag_out(flag));

   // free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [17:0] a,
         input logic [15:0] d, input logic [1:0] b);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= {16'h0000, d};
      be <= {2'b00, b};
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      rdata = rd_out;
      resp = resp_out;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wrap_up();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // hang guard, far beyond the hundred or so cycles the tests need
   initial begin
      #120000;
      miscompares++;
      wrap_up();
   end

   initial begin
      {rd, wr, wdog_first, addr, wdata, be} = '0;
      req = 32'hFFFF_FFFF;
      prio = {8{8'hE4}};
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      bus(0, 18'h3FEB0, 16'h0000, 2'h3);
      chk(rdata, 32'h0000_FFFF);
      bus(0, 18'h3FEB8, 16'h0000, 2'h3);
      chk(rdata, 32'h0000_FFFF);
      chk(isr, 32'h00);
      for (int i = 0; i < 5; i++) begin
         bus(1, rows[i].a, rows[i].d, rows[i].b);
         chk(resp, rows[i].r);
         bus(0, rows[i].a, 16'h0000, 2'h3);
         chk(rdata, rows[i].e);
         chk(resp, rows[i].r);
      end
      chk(mask, 32'hFF80_00B4);
      u_imsk_core_model.flag(5'd3, 1'b1);
      u_imsk_core_model.flag(5'd25, 1'b0);
      bus(0, 18'h3FEB0, 16'h0000, 2'h3);
      chk(rdata, 32'h0000_00BC);
      chk(grant, ~32'hFD80_00BC);
      // masked source 2 must not enter service
      u_imsk_core_model.ack(ACK_MASKABLE, 5'd2);
      @(negedge clk);
      chk(isr, 32'h00);
      for (int i = 0; i < 4; i++) begin
         u_imsk_core_model.ack(ACK_MASKABLE, srcs[i]);
         @(negedge clk);
         chk(isr, (32'h1 << (i + 1)) - 1);
      end
      u_imsk_core_model.ack(ACK_PIN_NMI, 5'd0);
      @(negedge clk);
      chk(isr, 32'h8F);
      u_imsk_core_model.ack(ACK_WATCHDOG, 5'd0);
      bus(0, 18'h3FEA0, 16'h0000, 2'h3);
      chk(rdata, 32'hCF);
      u_imsk_core_model.ret(RET_BREAK);
      u_imsk_core_model.ret(RET_BREAK_CONTEXT);
      @(negedge clk);
      chk(isr, 32'hCF);
      for (int i = 0; i < 6; i++) begin
         u_imsk_core_model.ret(i % 2 ? RET_CONTEXT : RET_VECTORED);
         @(negedge clk);
         chk(isr, rets[i]);
      end
      // watchdog ranked first now, so it leaves service first
      @(posedge clk);
      wdog_first <= 1'b1;
      u_imsk_core_model.ack(ACK_PIN_NMI, 5'd0);
      u_imsk_core_model.ack(ACK_WATCHDOG, 5'd0);
      u_imsk_core_model.ret(RET_VECTORED);
      @(negedge clk);
      chk(isr, 32'h80);
      // reset in mid-service clears in-service and sets every mask bit
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      chk(isr, 32'h00);
      chk(mask, 32'hFFFF_FFFF);
      resetn <= 1'b1;
      bus(0, 18'h3FEB0, 16'h0000, 2'h3);
      chk(rdata, 32'h0000_FFFF);
      wrap_up();
   end
endmodule
